// *** rtl/gim_pkg.sv ***
// types shared by the gpio interrupt block
package gim_pkg;

  typedef logic [7:0] gim_byte_t;
  typedef logic [7:0] gim_addr_t;
  typedef logic [31:0] gim_word_t;
  typedef logic [1:0] gim_resp_t;

  typedef struct packed {
    gim_byte_t sense;
    gim_byte_t both;
    gim_byte_t event_pol;
    gim_byte_t mask;
    gim_byte_t sel;
    gim_byte_t raw;
    gim_byte_t masked;
    gim_byte_t prev;
    logic combined;
    logic aw_v;
    gim_addr_t aw_addr;
    logic w_v;
    gim_byte_t w_data;
    logic w_lane0;
    logic b_v;
    gim_resp_t b_resp;
    logic r_v;
    gim_byte_t r_data;
    gim_resp_t r_resp;
  } gim_top_s;

endpackage : gim_pkg

// *** rtl/gim_regs.svh ***
// register map, reset values and bus codes for the gpio interrupt block
`ifndef GIM_REGS_SVH
`define GIM_REGS_SVH

`define GIM_ADDR_W 8
`define GIM_DATA_W 32
`define GIM_PINS 8

`define GIM_OFS_SENSE 8'h00
`define GIM_OFS_BOTH 8'h04
`define GIM_OFS_EVENT 8'h08
`define GIM_OFS_MASK 8'h0C
`define GIM_OFS_RAW 8'h10
`define GIM_OFS_MASKED 8'h14
`define GIM_OFS_CLEAR 8'h18
`define GIM_OFS_SELECT 8'h1C

`define GIM_RST_BYTE 8'h00

`define GIM_RESP_OKAY 2'h0
`define GIM_RESP_SLVERR 2'h2

`endif

// *** rtl/gim_sync.sv ***
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`include "gim_regs.svh"

module gim_sync #(
  parameter int WIDTH = `GIM_PINS
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  import gim_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] filt;
  } gim_sync_s;

  gim_sync_s st_q;
  gim_sync_s st_d;

  always_comb
  begin
    st_d = st_q;
    st_d.s1 = din;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    // s1 is never looked at here; only s2 and s3 vote
    for (int i = 0; i < WIDTH; i++)
    begin
      if (st_q.s2[i] == st_q.s3[i])
      begin
        st_d.filt[i] = st_q.s3[i];
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign dout = st_q.filt;

endmodule : gim_sync

// *** rtl/gim_top.sv ***
// gpio interrupt status, clear and control-source select with axi4-lite slave
//
// Notes on behaviour
// RULE1: raw bit set when pin trigger condition met
// RULE2: raw status read-only, cleared on reset
// RULE3: masked bit is raw and mask enable
// RULE4: masked bit low when no interrupt or masked
// RULE5: masked status read-only, cleared on reset
// RULE6: masked status driven out on eight wires
// RULE7: writing one clears edge detection, zero ignored
// RULE8: clear register write-only, reads zero
// RULE9: select one gives hardware, zero software control
// RULE10: select bits reset to zero, read-write
// RULE11: sense set detects level, clear detects edge
// RULE12: both-edges bit overrides event bit in edge mode
// RULE13: event bit picks rising/high or falling/low
// RULE14: mask enable gates pin and combined interrupt
// RULE15: edges latch until cleared, levels follow pin
`timescale 1ns/1ps
`include "gim_regs.svh"

module gim_top (
  input wire logic CLK_SYS,
  input wire logic SRST,
  input wire logic [`GIM_ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic [2:0] S_AXI_AWPROT,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [`GIM_DATA_W-1:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [`GIM_ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic [2:0] S_AXI_ARPROT,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [`GIM_DATA_W-1:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [`GIM_PINS-1:0] GPIO_IN,
  output logic [`GIM_PINS-1:0] MASKED_IRQ,
  output logic COMBINED_IRQ,
  output logic [`GIM_PINS-1:0] HW_CTRL_SEL
);
  import gim_pkg::*;

  gim_top_s st_q;
  gim_top_s st_d;

  gim_byte_t pin_lvl;
  gim_byte_t rise;
  gim_byte_t fall;
  gim_byte_t edge_hit;
  gim_byte_t level_hit;
  gim_byte_t clr_pulse;
  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic do_write;
  logic wr_known;
  logic rd_known;
  gim_byte_t rd_val;
  gim_addr_t rd_addr;

  // pins come from outside the clock domain
  gim_sync #(
    .WIDTH(`GIM_PINS)
  ) u_sync (
    .clk(CLK_SYS),
    .srst(SRST),
    .din(GPIO_IN),
    .dout(pin_lvl)
  );

  // protection bits are accepted but carry no meaning here
  assign aw_hs = S_AXI_AWVALID && S_AXI_AWREADY;
  assign w_hs = S_AXI_WVALID && S_AXI_WREADY;
  assign ar_hs = S_AXI_ARVALID && S_AXI_ARREADY;
  assign do_write = st_q.aw_v && st_q.w_v && !st_q.b_v;

  always_comb
  begin
    unique case (st_q.aw_addr)
      `GIM_OFS_SENSE, `GIM_OFS_BOTH, `GIM_OFS_EVENT, `GIM_OFS_MASK,
      `GIM_OFS_RAW, `GIM_OFS_MASKED, `GIM_OFS_CLEAR, `GIM_OFS_SELECT:
        wr_known = 1'b1;
      default:
        wr_known = 1'b0;
    endcase
  end

  // write strobe of the clear register, one cycle wide
  always_comb
  begin
    clr_pulse = `GIM_RST_BYTE;
    if (do_write && st_q.w_lane0 && st_q.aw_addr == `GIM_OFS_CLEAR)
    begin
      clr_pulse = st_q.w_data; // [RULE7]
    end
  end

  // edge detection on the filtered pin level
  assign rise = pin_lvl & ~st_q.prev;
  assign fall = ~pin_lvl & st_q.prev;

  always_comb
  begin
    edge_hit = '0;
    level_hit = '0;
    for (int i = 0; i < `GIM_PINS; i++)
    begin
      if (st_q.both[i])
      begin
        edge_hit[i] = rise[i] | fall[i]; // [RULE12]
      end
      else if (st_q.event_pol[i])
      begin
        edge_hit[i] = rise[i]; // [RULE13]
      end
      else
      begin
        edge_hit[i] = fall[i]; // [RULE13]
      end
      level_hit[i] = (pin_lvl[i] == st_q.event_pol[i]); // [RULE13]
    end
  end

  // read mux; the clear register holds nothing readable
  assign rd_addr = S_AXI_ARADDR & 8'hFC;

  always_comb
  begin
    rd_val = `GIM_RST_BYTE;
    rd_known = 1'b1;
    unique case (rd_addr)
      `GIM_OFS_SENSE:
        rd_val = st_q.sense;
      `GIM_OFS_BOTH:
        rd_val = st_q.both;
      `GIM_OFS_EVENT:
        rd_val = st_q.event_pol;
      `GIM_OFS_MASK:
        rd_val = st_q.mask;
      `GIM_OFS_RAW:
        rd_val = st_q.raw; // [RULE2]
      `GIM_OFS_MASKED:
        rd_val = st_q.masked; // [RULE5]
      `GIM_OFS_CLEAR:
        rd_val = `GIM_RST_BYTE; // [RULE8]
      `GIM_OFS_SELECT:
        rd_val = st_q.sel; // [RULE10]
      default:
        rd_known = 1'b0;
    endcase
  end

  always_comb
  begin
    st_d = st_q;

    // write address and data are captured independently
    if (aw_hs)
    begin
      st_d.aw_v = 1'b1;
      st_d.aw_addr = S_AXI_AWADDR & 8'hFC;
    end
    if (w_hs)
    begin
      st_d.w_v = 1'b1;
      st_d.w_data = S_AXI_WDATA[7:0];
      st_d.w_lane0 = S_AXI_WSTRB[0];
    end

    if (st_q.b_v && S_AXI_BREADY)
    begin
      st_d.b_v = 1'b0;
    end

    if (do_write)
    begin
      st_d.aw_v = 1'b0;
      st_d.w_v = 1'b0;
      st_d.b_v = 1'b1;
      st_d.b_resp = wr_known ? `GIM_RESP_OKAY : `GIM_RESP_SLVERR;
      // only the low byte lane holds register bits
      if (st_q.w_lane0)
      begin
        unique case (st_q.aw_addr)
          `GIM_OFS_SENSE:
            st_d.sense = st_q.w_data; // [RULE11]
          `GIM_OFS_BOTH:
            st_d.both = st_q.w_data; // [RULE12]
          `GIM_OFS_EVENT:
            st_d.event_pol = st_q.w_data; // [RULE13]
          `GIM_OFS_MASK:
            st_d.mask = st_q.w_data; // [RULE14]
          `GIM_OFS_SELECT:
            st_d.sel = st_q.w_data; // [RULE10]
          default:
            st_d.sense = st_q.sense; // status writes are dropped [RULE2] [RULE5]
        endcase
      end
    end

    if (st_q.r_v && S_AXI_RREADY)
    begin
      st_d.r_v = 1'b0;
    end
    if (ar_hs)
    begin
      st_d.r_v = 1'b1;
      st_d.r_data = rd_val;
      st_d.r_resp = rd_known ? `GIM_RESP_OKAY : `GIM_RESP_SLVERR;
    end

    st_d.prev = pin_lvl;

    // a detection in the same cycle as its clear is kept
    for (int i = 0; i < `GIM_PINS; i++)
    begin
      if (st_q.sense[i])
      begin
        st_d.raw[i] = level_hit[i]; // [RULE11] [RULE15] [RULE1]
      end
      else
      begin
        st_d.raw[i] = (st_q.raw[i] & ~clr_pulse[i]) | edge_hit[i]; // [RULE15] [RULE7] [RULE1]
      end
    end

    // masked copy tracks the new raw and mask in the same edge
    st_d.masked = st_d.raw & st_d.mask; // [RULE3] [RULE4] [RULE14]
    st_d.combined = |st_d.masked; // [RULE14]
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (SRST)
    begin
      st_q <= '0; // [RULE2] [RULE5] [RULE8] [RULE10] [RULE11] [RULE14]
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // each write channel holds one beat and reopens at the commit; the next commit waits for the response to drain
  assign S_AXI_AWREADY = !st_q.aw_v;
  assign S_AXI_WREADY = !st_q.w_v;
  assign S_AXI_BVALID = st_q.b_v;
  assign S_AXI_BRESP = st_q.b_resp;
  assign S_AXI_ARREADY = !st_q.r_v;
  assign S_AXI_RVALID = st_q.r_v;
  assign S_AXI_RDATA = {24'h000000, st_q.r_data};
  assign S_AXI_RRESP = st_q.r_resp;

  assign MASKED_IRQ = st_q.masked; // [RULE6]
  assign COMBINED_IRQ = st_q.combined; // [RULE14]
  assign HW_CTRL_SEL = st_q.sel; // [RULE9]

endmodule : gim_top

// *** tb/gim_properties.sv ***
// port assertions for the gpio interrupt block
`timescale 1ns/1ps
module gim_properties (
  input wire logic CLK_SYS,
  input wire logic SRST,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] MASKED_IRQ,
  input wire logic COMBINED_IRQ,
  input wire logic [7:0] HW_CTRL_SEL
);
  default clocking @(posedge CLK_SYS);
  endclocking
  default disable iff (SRST);
  a_rst_clear: assert property ($past(SRST) |-> MASKED_IRQ == 8'h00 && HW_CTRL_SEL == 8'h00)
    else $error("outputs not clear after reset");
  // select moves only at a write commit, the same edge bvalid rises
  a_sel_commit: assert property ($changed(HW_CTRL_SEL) |-> $rose(S_AXI_BVALID))
    else $error("select changed outside a write");
  a_comb_or: assert property (COMBINED_IRQ == |MASKED_IRQ)
    else $error("combined line differs from masked or");
  a_ar_block: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("read address taken while answer pending");
  a_b_drop: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
    else $error("write answer repeated");
  a_r_drop: assert property (S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID)
    else $error("read answer repeated");
  a_r_cause: assert property ($rose(S_AXI_RVALID) |-> $past(S_AXI_ARVALID) && $past(S_AXI_ARREADY))
    else $error("read answer without request");
  a_rdata_hi: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h000000)
    else $error("upper read data not zero");
  c_irq: cover property ($rose(COMBINED_IRQ));
  c_wr: cover property (S_AXI_BVALID && S_AXI_BREADY);
  c_sel: cover property (HW_CTRL_SEL == 8'hA5);
endmodule : gim_properties

bind gim_top gim_properties u_prop (.CLK_SYS, .SRST, .S_AXI_ARVALID, .S_AXI_ARREADY,
  .S_AXI_RVALID, .S_AXI_RREADY, .S_AXI_RDATA, .S_AXI_BVALID, .S_AXI_BREADY,
  .MASKED_IRQ, .COMBINED_IRQ, .HW_CTRL_SEL);

// *** tb/testbench.sv ***
// self-checking bench for the gpio interrupt block
`timescale 1ns/1ps
`include "gim_regs.svh"
module testbench;
  import gim_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
  logic awr, wrr, bv, arr, rv, cirq;
  gim_addr_t awa = 8'h00, ara = 8'h00;
  gim_word_t wd = 32'h0, rdat;
  gim_resp_t br, rr;
  gim_byte_t pin = 8'h00, mirq, sel;
  int failures = 0, total_checks = 0, cyc = 0;

  always #12.5 clk = ~clk;

  gim_top dut (.CLK_SYS(clk), .SRST(srst), .S_AXI_AWADDR(awa), .S_AXI_AWPROT(3'h0),
    .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF),
    .S_AXI_WVALID(wv), .S_AXI_WREADY(wrr), .S_AXI_BRESP(br), .S_AXI_BVALID(bv),
    .S_AXI_BREADY(bre), .S_AXI_ARADDR(ara), .S_AXI_ARPROT(3'h0), .S_AXI_ARVALID(arv),
    .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdat), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv),
    .S_AXI_RREADY(rre), .GPIO_IN(pin), .MASKED_IRQ(mirq), .COMBINED_IRQ(cirq),
    .HW_CTRL_SEL(sel));

  task end_sim;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_sim

  task chk(input gim_word_t g, input gim_word_t e);
    total_checks++;
    if (g !== e)
    begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  // ready sampled at the falling edge, so release lands cleanly on the next rise
  task bus(input logic w, input gim_addr_t a, input gim_byte_t d, input gim_resp_t er,
    output gim_word_t q);
    logic ka, kw, kr, dn;
    gim_resp_t r;
    @(posedge clk);
    awa <= a;
    ara <= a;
    wd <= {24'h000000, d};
    awv <= w;
    wv <= w;
    arv <= !w;
    bre <= 1'b1;
    rre <= 1'b1;
    dn = 1'b0;
    while (!dn)
    begin
      @(negedge clk);
      ka = awv && awr;
      kw = wv && wrr;
      kr = arv && arr;
      dn = w ? bv : rv;
      r = w ? br : rr;
      q = rdat;
      @(posedge clk);
      if (ka) awv <= 1'b0;
      if (kw) wv <= 1'b0;
      if (kr) arv <= 1'b0;
    end
    bre <= 1'b0;
    rre <= 1'b0;
    chk(32'(r), 32'(er));
  endtask : bus

  task wr(input gim_addr_t a, input gim_byte_t d);
    gim_word_t q;
    bus(1'b1, a, d, `GIM_RESP_OKAY, q);
  endtask : wr

  task rd(input gim_addr_t a, input gim_byte_t e);
    gim_word_t q;
    bus(1'b0, a, 8'h00, `GIM_RESP_OKAY, q);
    chk(q, 32'(e));
  endtask : rd

  // pins pass a synchroniser, so let them settle before looking
  task pins(input gim_byte_t v);
    @(posedge clk);
    pin <= v;
    repeat (6) @(posedge clk);
  endtask : pins

  task t_rst;
    gim_word_t q;
    for (int i = 0; i < 8; i++) rd(8'(4 * i), 8'h00);
    bus(1'b0, 8'h20, 8'h00, `GIM_RESP_SLVERR, q);
    chk(q, 32'h0);
    $display("t_rst done");
  endtask : t_rst

  task t_sel;
    gim_word_t q;
    wr(`GIM_OFS_SELECT, 8'hA5);
    chk(32'(sel), 32'hA5);
    rd(`GIM_OFS_SELECT, 8'hA5);
    wr(`GIM_OFS_RAW, 8'hFF);
    rd(`GIM_OFS_RAW, 8'h00);
    wr(`GIM_OFS_MASKED, 8'hFF);
    rd(`GIM_OFS_MASKED, 8'h00);
    bus(1'b1, 8'h20, 8'hFF, `GIM_RESP_SLVERR, q);
    wr(`GIM_OFS_SELECT, 8'h00);
    chk(32'(sel), 32'h0);
    $display("t_sel done");
  endtask : t_sel

  task t_edge;
    wr(`GIM_OFS_MASK, 8'h0F);
    wr(`GIM_OFS_EVENT, 8'hFF);
    pins(8'hFF);
    rd(`GIM_OFS_RAW, 8'hFF);
    rd(`GIM_OFS_MASKED, 8'h0F);
    chk(32'({cirq, mirq}), 32'h10F);
    pins(8'h00);
    rd(`GIM_OFS_RAW, 8'hFF);
    wr(`GIM_OFS_CLEAR, 8'h0F);
    rd(`GIM_OFS_CLEAR, 8'h00);
    rd(`GIM_OFS_RAW, 8'hF0);
    chk(32'({cirq, mirq}), 32'h0);
    wr(`GIM_OFS_EVENT, 8'h00);
    wr(`GIM_OFS_CLEAR, 8'hFF);
    pins(8'hFF);
    rd(`GIM_OFS_RAW, 8'h00);
    pins(8'h00);
    rd(`GIM_OFS_RAW, 8'hFF);
    wr(`GIM_OFS_CLEAR, 8'hFF);
    wr(`GIM_OFS_BOTH, 8'h0F);
    pins(8'hFF);
    rd(`GIM_OFS_RAW, 8'h0F);
    $display("t_edge done");
  endtask : t_edge

  task t_lvl;
    wr(`GIM_OFS_SENSE, 8'hFF);
    wr(`GIM_OFS_EVENT, 8'h3C);
    rd(`GIM_OFS_RAW, 8'h3C);
    wr(`GIM_OFS_CLEAR, 8'hFF);
    rd(`GIM_OFS_RAW, 8'h3C);
    pins(8'h00);
    rd(`GIM_OFS_RAW, 8'hC3);
    chk(32'(mirq), 32'h03);
    $display("t_lvl done");
  endtask : t_lvl

  // reset in mid-run, held two edges so no output change slips past the disable
  task t_mid;
    wr(`GIM_OFS_SELECT, 8'h5A);
    chk(32'(sel), 32'h5A);
    chk(32'(mirq), 32'h03);
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    chk(32'({cirq, mirq}), 32'h0);
    chk(32'(sel), 32'h0);
    rd(`GIM_OFS_SENSE, 8'h00);
    rd(`GIM_OFS_MASK, 8'h00);
    rd(`GIM_OFS_RAW, 8'h00);
    rd(`GIM_OFS_MASKED, 8'h00);
    rd(`GIM_OFS_SELECT, 8'h00);
    $display("t_mid done");
  endtask : t_mid

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 4000)
    begin
      failures++;
      end_sim;
    end
  end

  initial
  begin
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    t_rst;
    t_sel;
    t_edge;
    t_lvl;
    t_mid;
    end_sim;
  end
endmodule : testbench
